// ---- core/rds_defines.vh ----
/*
 * Constants for the reset domain sequencer: modes, timing counts, strap defaults.
 * Assumes a 125 MHz core-side clock and a slow RTC-side clock sampled as a plain input.
 */
`ifndef RDS_DEFINES_VH
`define RDS_DEFINES_VH
`define RDS_MODE_W        2
`define RDS_MODE_OFF      2'h0
`define RDS_MODE_NORMAL   2'h1
`define RDS_MODE_SLEEP    2'h2
`define RDS_MODE_RETAIN   2'h3
`define RDS_SYNC_STAGES   2
`define RDS_BK_REL_EDGES  3'h2
`define RDS_STRAP_RESET   1'h1
`endif

// ---- core/rds_sync.v ----
/*
 * Two-flop level synchronizer with constant reset value.
 * Assumes d comes from outside the clk domain.
 */
`timescale 1ns/1ps
module rds_sync
#(
  parameter RST_VAL = 1'b0
)
(
  input  wire clk, // Sampling clock
  input  wire rst, // Async reset, active high
  input  wire d,   // Asynchronous level
  output wire q    // Synchronized level
);
  reg meta_q;
  reg sync_q;
  // First stage is read only by the second
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule

// ---- core/rds_top.v ----
/*
 * Reset domain sequencer: core reset combining, backup reset, supply select, mode.
 * Assumes monitor flags are asynchronous levels; RTC clock is sampled as a plain input.
 */
`timescale 1ns/1ps
`include "rds_defines.vh"
module rds_top
(
  input  wire       clk,              // 125 MHz clock
  input  wire       rst,              // Async reset, active high
  input  wire       io_low,           // IO supply below 1.7V
  input  wire       conv_in_low,      // converter_input_monitor below 1.2V
  input  wire       bypass_mode,      // Converter bypass operation
  input  wire       core_low,         // Core below 90% of target
  input  wire       backup_low,       // backup_supply_monitor below 0.6V
  input  wire       ext_reset_n,      // External reset pin, active low
  input  wire       sw_reset,         // Firmware software reset
  input  wire       wdog_reset,       // Watchdog reset output
  input  wire       rtc_soft_reset,   // Firmware RTC soft reset
  input  wire       main_present,     // Main supply present
  input  wire       io_present,       // IO supply present
  input  wire       bat_present,      // battery_backup_supply present
  input  wire       sleep_req,        // Firmware sleep request
  input  wire       rtc_clk,          // 32.768 kHz RTC clock
  input  wire       rtc_ext_sel,      // 1: external digital clock
  input  wire       strap_boot,       // Boot selection strap
  input  wire       strap_if,         // Interface selection strap
  output reg        core_rst_q,       // Core domain reset
  output reg        backup_rst_q,     // Backup domain reset
  output reg        backup_from_io_q, // 1: backup from IO, 0: battery
  output reg        core_power_on_q,  // Baseband, RF, CPU powered
  output reg        rtc_run_q,        // RTC timekeeping running
  output reg        ram_retain_q,     // Retention RAM holds data
  output reg [1:0]  mode_q,           // Operating mode
  output reg        rtc_osc_ext_q,    // RTC source select
  output reg        strap_boot_q,     // Latched boot strap
  output reg        strap_if_q        // Latched interface strap
);
  wire [12:0] s;
  wire [12:0] raw;
  // Pin bundle order: 0 converter monitor, 1 core monitor, 2 backup monitor,
  // 3 reset pin (low means request), 4 software reset, 5 watchdog, 6 RTC soft reset,
  // 7 main present, 8 IO present, 9 battery present, 10 sleep, 11 RTC clock,
  // 12 RTC source select. Pins enter raw, with no gate in front of the flops.
  // Flop reset value 0 reads as supply absent and reset pin asserted, so the
  // core stays held until the first real samples arrive.
  assign raw = {rtc_ext_sel, rtc_clk, sleep_req, bat_present, io_present, main_present,
                rtc_soft_reset, wdog_reset, sw_reset, ext_reset_n, backup_low, core_low,
                conv_in_low};
  // Every pin passes two flops before use,
  // so no logic ever reads a pin straight from the package
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi = gi + 1)
    begin : g_sync
      rds_sync #(.RST_VAL(1'b0)) u_sync
      (
        .clk (clk),
        .rst (rst),
        .d   (raw[gi]),
        .q   (s[gi])
      );
    end
  endgenerate
  wire io_low_s;
  rds_sync #(.RST_VAL(1'b1)) u_io
  (
    .clk (clk),
    .rst (rst),
    .d   (io_low),
    .q   (io_low_s)
  );
  wire bypass_s;
  wire strap_boot_s;
  wire strap_if_s;
  // Bypass is synchronised on its own so the AND below sees two settled levels
  rds_sync #(.RST_VAL(1'b0)) u_byp
  (
    .clk (clk),
    .rst (rst),
    .d   (bypass_mode),
    .q   (bypass_s)
  );
  // Straps idle high, so their flops reset to the pulled-up level
  rds_sync #(.RST_VAL(1'b1)) u_strap_boot
  (
    .clk (clk),
    .rst (rst),
    .d   (strap_boot),
    .q   (strap_boot_s)
  );
  rds_sync #(.RST_VAL(1'b1)) u_strap_if
  (
    .clk (clk),
    .rst (rst),
    .d   (strap_if),
    .q   (strap_if_s)
  );
  // One term per core source, except the firmware and supply-present terms that cover two each; the converter monitor only counts in bypass operation
  wire req_io   = io_low_s;
  wire req_conv = s[0] & bypass_s;
  wire req_core = s[1];
  wire req_bk   = s[2];
  wire req_pin  = ~s[3];
  wire req_fw   = s[4] | s[5];
  wire req_pwr  = ~s[7] | ~s[8];
  // Any single source is enough to hold the core
  wire core_req = req_io | req_conv | req_core | req_bk | req_pin | req_fw | req_pwr;
  // Release stretch: a request sets both stages at once, and reset falls only on the
  // third clean edge. Assertion also waits for the input synchronisers, a three-edge
  // latency traded for a glitch-free reset that never reads a raw pin.
  reg [1:0] crel_q;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      crel_q <= 2'h3;
    else if (core_req)
      crel_q <= 2'h3;
    else
      crel_q <= {crel_q[0], 1'b0};
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      core_rst_q <= 1'b1;
    else
      core_rst_q <= core_req | crel_q[1];
  end
  // Backup domain: powered when IO or battery is present. With the battery in place
  // bk_pwr never drops, so supply changes on the core side cannot reach this reset.
  // A rise of bk_pwr is the first-power event that forces one reset pass.
  wire bk_pwr = s[8] | s[9];
  reg  bk_pwr_q;
  reg  rtc_prev_q;
  reg  [2:0] bk_cnt_q;
  wire rtc_rise = s[11] & ~rtc_prev_q;
  wire bk_req = s[2] | s[6] | ~bk_pwr | (bk_pwr & ~bk_pwr_q);
  // The RTC clock is sampled as data; a new request restarts the edge count
  // Release counted only on RTC edges, core state plays no part
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bk_pwr_q     <= 1'b0;
      rtc_prev_q   <= 1'b0;
      bk_cnt_q     <= 3'h0;
      backup_rst_q <= 1'b1;
    end
    else
    begin
      bk_pwr_q   <= bk_pwr;
      rtc_prev_q <= s[11];
      if (bk_req)
      begin
        bk_cnt_q     <= 3'h0;
        backup_rst_q <= 1'b1;
      end
      else if (rtc_rise && backup_rst_q)
      begin
        if (bk_cnt_q == `RDS_BK_REL_EDGES)
          backup_rst_q <= 1'b0;
        else
          bk_cnt_q <= bk_cnt_q + 3'h1;
      end
    end
  end
  // Supply select and mode
  // Sleep needs main and IO; without them only the battery keeps retention alive
  reg [1:0] mode_d;
  always @*
  begin
    if (s[7] && s[8])
      mode_d = s[10] ? `RDS_MODE_SLEEP : `RDS_MODE_NORMAL;
    else if (s[9])
      mode_d = `RDS_MODE_RETAIN;
    else
      mode_d = `RDS_MODE_OFF;
  end
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q           <= `RDS_MODE_OFF;
      backup_from_io_q <= 1'b0;
      core_power_on_q  <= 1'b0;
      rtc_run_q        <= 1'b0;
      ram_retain_q     <= 1'b0;
      rtc_osc_ext_q    <= 1'b0;
    end
    else
    begin
      mode_q           <= mode_d;
      backup_from_io_q <= s[8] & ~io_low_s;
      // Core islands are powered in normal mode only
      case (mode_d)
        `RDS_MODE_NORMAL: core_power_on_q <= 1'b1;
        `RDS_MODE_SLEEP:  core_power_on_q <= 1'b0;
        `RDS_MODE_RETAIN: core_power_on_q <= 1'b0;
        default:          core_power_on_q <= 1'b0;
      endcase
      rtc_run_q        <= bk_pwr & ~backup_rst_q;
      ram_retain_q     <= bk_pwr & ~backup_rst_q;
      rtc_osc_ext_q    <= s[12];
    end
  end
  // Straps caught while the core is held, not under async reset. Capture stops once
  // the core runs but resumes at every later core reset, so strap pins used as general
  // IO can change the captured configuration only while the core is held again.
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      strap_boot_q <= `RDS_STRAP_RESET;
      strap_if_q   <= `RDS_STRAP_RESET;
    end
    else if (core_rst_q)
    begin
      strap_boot_q <= strap_boot_s;
      strap_if_q   <= strap_if_s;
    end
  end
endmodule

// ---- testbench/rds_checker.sv ----
/* Port-level timing checks for the reset sequencer.
   Assumes bind to rds_top and the stated sync latencies. */
`timescale 1ns/1ps
`include "rds_defines.vh"
module rds_checker
(
  input wire       clk, rst,                                              // Clock, reset
  input wire       io_low, conv_in_low, bypass_mode, core_low, backup_low, // Monitors
  input wire       ext_reset_n, sw_reset, wdog_reset, rtc_soft_reset,      // Requests
  input wire       main_present, io_present, bat_present,                 // Supplies
  input wire       core_rst_q, backup_rst_q, backup_from_io_q,            // Resets
  input wire       core_power_on_q, strap_boot_q,                         // Power, strap
  input wire [1:0] mode_q                                                 // Mode
);
  wire src;
  wire bk_src;
  // Converter monitor only counts in bypass
  assign src = io_low | (conv_in_low & bypass_mode) | core_low | backup_low | !ext_reset_n
             | sw_reset | wdog_reset | !main_present | !io_present;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence quiet_s; !src [*8]; endsequence
  assign bk_src = backup_low | rtc_soft_reset;
  core_set_a: assert property ($rose(src) |-> ##[2:3] core_rst_q) else $error("core set");
  core_rel_a: assert property (quiet_s |=> !core_rst_q) else $error("core rel");
  bk_set_a: assert property ($rose(bk_src) |-> ##[1:3] backup_rst_q) else $error("bk set");
  bk_keep_a: assert property ((bat_present & !bk_src) [*6] |=> !$rose(backup_rst_q))
    else $error("bk keep");
  bk_sel_a: assert property ($stable(io_present & !io_low) [*4] |-> backup_from_io_q == (io_present & !io_low))
    else $error("bk sel");
  off_hold_a: assert property ((!main_present | !io_present) [*4] |-> core_rst_q) else $error("off");
  sleep_off_a: assert property (mode_q == `RDS_MODE_SLEEP |-> !core_power_on_q) else $error("sleep");
  strap_keep_a: assert property (!core_rst_q ##1 !core_rst_q |-> $stable(strap_boot_q))
    else $error("strap");
endmodule
bind rds_top rds_checker u_chk (.clk, .rst, .io_low, .conv_in_low, .bypass_mode, .core_low,
  .backup_low, .ext_reset_n, .sw_reset, .wdog_reset, .rtc_soft_reset, .main_present, .io_present,
  .bat_present, .core_rst_q, .backup_rst_q, .backup_from_io_q, .core_power_on_q, .strap_boot_q, .mode_q);

// ---- testbench/rds_partner.sv ----
/* Far side: RTC oscillator, reset pin, straps.
   Assumes the bench asks for a pin reset. */
`timescale 1ns/1ps
module rds_partner
(
  input  wire pin_req,     // Pull reset pin low
  input  wire strap_drop,  // Let straps fall after power-on
  output reg  rtc_clk,     // RTC clock, sped up to keep runs short
  output wire ext_reset_n, // Reset pin
  output wire strap_boot,  // Boot strap
  output wire strap_if     // Interface strap
);
  // Oscillator runs free, like a crystal
  initial rtc_clk = 1'h0;
  always #200 rtc_clk = ~rtc_clk;
  // Pin pulled up unless a reset is asked for
  assign ext_reset_n = !pin_req;
  // Straps stay high at power-on; the bench may only drop them once the core runs
  assign strap_boot  = !strap_drop;
  assign strap_if    = !strap_drop;
endmodule

// ---- testbench/tb_top.sv ----
/* Self-checking bench for rds_top.
   Assumes the checker is bound and the partner drives pins. */
`timescale 1ns/1ps
`include "rds_defines.vh"
module tb_top;
  reg        clk, rst, sleep_req, rtc_ext_sel, rtc_soft_reset, bat_present;
  reg  [9:0] v;
  reg        bk_last, bk_exp, strap_drop;
  reg [31:0] seed;
  integer    errors, cmp_count, i, n;
  wire       rtc_clk, ext_reset_n, strap_boot, strap_if, core_rst_q, backup_rst_q, backup_from_io_q;
  wire       core_power_on_q, rtc_run_q, ram_retain_q, rtc_osc_ext_q, strap_boot_q, strap_if_q;
  wire [1:0] mode_q;
  rds_partner u_far (.pin_req(v[5]), .strap_drop, .rtc_clk, .ext_reset_n, .strap_boot, .strap_if);
  rds_top u_dut (.clk, .rst, .io_low(v[0]), .conv_in_low(v[1]), .bypass_mode(v[2]), .core_low(v[3]),
    .backup_low(v[4]), .ext_reset_n, .sw_reset(v[6]), .wdog_reset(v[7]), .rtc_soft_reset, // missed restart
    .main_present(!v[8]), .io_present(!v[9]), .bat_present, .sleep_req, .rtc_clk, .rtc_ext_sel,
    .strap_boot, .strap_if, .core_rst_q, .backup_rst_q, .backup_from_io_q, .core_power_on_q,
    .rtc_run_q, .ram_retain_q, .mode_q, .rtc_osc_ext_q, .strap_boot_q, .strap_if_q);
  // 125 MHz clock
  always #4 clk = ~clk;
  // Expected core reset; converter monitor needs bypass
  function exp_core(input [9:0] s);
    exp_core = s[0] | (s[1] & s[2]) | (|s[9:3]);
  endfunction
  function [31:0] xs(input [31:0] x);
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task check(input [39:0] name, input [3:0] seen, input [3:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      errors = errors + 1;
      $display("BAD %0s exp %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Backup release needs several slow edges, so poll with a limit
  task wait_bk;
    for (n = 0; n < 3000 && backup_rst_q !== 1'h0; n = n + 1)
      @(posedge clk);
    if (backup_rst_q !== 1'h0)
    begin
      errors = errors + 1;
      finish_test;
    end
  endtask
  task apply(input [9:0] s);
    @(posedge clk);
    v <= s;
    rtc_ext_sel <= seed[15];
    repeat (10) @(posedge clk);
    #1;
    check("core", core_rst_q, exp_core(s));
    check("bkio", backup_from_io_q, !s[9] & !s[0]);
    // Backup release takes three slow edges, so a monitor fault just cleared still holds it
    bk_exp = s[4] | bk_last;
    check("bkrst", backup_rst_q, bk_exp);
    check("osc", rtc_osc_ext_q, rtc_ext_sel);
    if (s[9:8] == 2'h3)
      check("ret", {mode_q == `RDS_MODE_RETAIN, rtc_run_q & ram_retain_q & !core_power_on_q},
            {1'h1, !bk_exp});
    bk_last = s[4];
  endtask
  // Main sequence: single sources, random mixes, sleep, RTC soft reset
  initial
  begin
    {clk, sleep_req, rtc_ext_sel, rtc_soft_reset, bk_last, bk_exp, strap_drop, v} = 0;
    {rst, bat_present, seed, errors, cmp_count} = {2'h3, 32'h4D, 64'h0}; // battery never removed
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    wait_bk;
    check("strap", strap_boot_q & strap_if_q, 1'h1);
    for (i = 0; i < 60; i = i + 1)
    begin
      seed = xs(seed);
      apply(i < 10 ? 10'h001 << i : i == 10 ? 10'h300 : seed[9:0] & (seed[12:10] == 0 ? 10'h3FF : 10'h006));
      apply(10'h000);
      wait_bk;
    end
    sleep_req <= 1'h1;
    repeat (10) @(posedge clk);
    check("sleep", {mode_q == `RDS_MODE_SLEEP, rtc_run_q & ram_retain_q & !core_power_on_q}, 2'h3);
    sleep_req <= 1'h0;
    rtc_soft_reset <= 1'h1;
    repeat (10) @(posedge clk);
    check("soft", {backup_rst_q, core_rst_q, mode_q == `RDS_MODE_NORMAL}, 3'h5);
    rtc_soft_reset <= 1'h0;
    wait_bk;
    // Straps fall while the core runs: the captured values must not follow
    @(posedge clk);
    strap_drop <= 1'h1;
    repeat (10) @(posedge clk);
    check("strap", {strap_boot_q, strap_if_q}, 2'h3);
    strap_drop <= 1'h0;
    // Second reset in mid-run, then a full recovery of both domains
    rst <= 1'h1;
    @(posedge clk);
    #1;
    check("rst", {core_rst_q, backup_rst_q, mode_q}, 4'hC);
    @(posedge clk);
    rst <= 1'h0;
    wait_bk;
    repeat (10) @(posedge clk);
    check("again", {core_rst_q, backup_rst_q}, 2'h0);
    finish_test;
  end
endmodule
